// ==== bench/asc_core_model.sv ====
// Behavioural model of the analogue converter core and its inputs.
// Assumes the control block drives power, reset and input selection.
`timescale 1ns/10ps
module asc_core_model
    import asc_pkg::*;
#(
    parameter logic [11:0] BG_CODE  = 12'hA5C, // Bandgap value, arbitrary
    parameter logic [7:0]  CHAN_LOW = 8'hA6    // Low byte of channel value
) (
    input  wire logic        ref_clk,          // System clock
    input  wire logic        rst_n,            // Async reset, active low
    input  wire logic        conv_power_q,     // Converter powered
    input  wire logic        conv_reset_q,     // Converter held in reset
    input  wire logic        bandgap_power_q,  // Bandgap circuit on
    input  wire logic        bandgap_route_q,  // Bandgap on input
    input  wire logic        ext_chan_en_q,    // External channel on
    input  wire logic [3:0]  channel_select_q, // Channel code
    output logic      [11:0] adc_data          // Conversion value
);
    // ==========================================================
    // Input value; toggling junk when unpowered, reset or floating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_data <= 12'h5A5;
        end else if (!conv_power_q || conv_reset_q) begin
            adc_data <= ~adc_data;
        end else if (bandgap_route_q && bandgap_power_q) begin
            adc_data <= BG_CODE;
        end else if (ext_chan_en_q) begin
            adc_data <= {channel_select_q, CHAN_LOW};
        end else begin
            adc_data <= ~adc_data;
        end
    end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the converter sequencing control block.
// Assumes the analogue core model answers on adc_data.
`timescale 1ns/10ps
module tb;
    import asc_pkg::*;
    localparam int          TIMEOUT = 40000;   // Cycles for the whole run
    localparam int          SETTLE  = 20;      // Bandgap and power-up wait
    localparam logic [11:0] BG_CODE = 12'hA5C; // Model bandgap value
    logic        ref_clk, rst_n, wr, rd, lv_rst, lv_det;
    logic [1:0]  addr;
    logic [7:0]  wdata, rdata_q;
    logic [11:0] adc_data;
    logic        clk_en, c_rst, c_pwr, bg_pwr, bg_route, ext_en;
    logic        ref_sel, ref_claim, irq;
    logic [3:0]  chan;
    int          num_errors, n_checks, cycles;

    asc_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .low_voltage_reset(lv_rst), .low_voltage_detect(lv_det),
        .adc_data(adc_data), .conv_clk_en_q(clk_en), .conv_reset_q(c_rst),
        .conv_power_q(c_pwr), .bandgap_power_q(bg_pwr),
        .bandgap_route_q(bg_route), .ext_chan_en_q(ext_en),
        .channel_select_q(chan), .vref_pin_sel_q(ref_sel),
        .vref_pin_claim_q(ref_claim), .irq_request_q(irq));
    asc_core_model #(.BG_CODE(BG_CODE)) core_u (.ref_clk(ref_clk),
        .rst_n(rst_n), .conv_power_q(c_pwr), .conv_reset_q(c_rst),
        .bandgap_power_q(bg_pwr), .bandgap_route_q(bg_route),
        .ext_chan_en_q(ext_en), .channel_select_q(chan),
        .adc_data(adc_data));

    // ==========================================================
    // Clock, 8 ns period
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            num_errors++;
            wrap_up();
        end
    end
    // ==========================================================
    // Compare and bus tasks
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 d = rdata_q;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_ctl1();
        logic [7:0] d;
        reg_rd(ASC_CTL0_OFS, d);
        chk_val(d, 8'h60);
        reg_wr(ASC_CTL1_OFS, 8'h40);
        reg_wr(ASC_CTL1_OFS, 8'hFF);
        reg_rd(ASC_CTL1_OFS, d);
        chk_val(d, 8'hD7);
        chk_bit(bg_route, 1'b1);
        chk_bit(ext_en, 1'b0);
        chk_bit(ref_sel, 1'b1);
        chk_bit(ref_claim, 1'b1);
        reg_wr(ASC_CTL1_OFS, 8'h00);
        reg_rd(ASC_CTL1_OFS, d);
        chk_bit(ref_sel, 1'b0);
        chk_bit(ref_claim, 1'b0);
        chk_bit(bg_pwr, 1'b0);
        @(posedge ref_clk);
        lv_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_bit(bg_pwr, 1'b1);
        lv_rst <= 1'b0;
        lv_det <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_bit(bg_pwr, 1'b1);
        lv_det <= 1'b0;
    endtask
    task automatic t_chan();
        logic [7:0] d;
        for (int c = 0; c < 16; c++) begin
            reg_wr(ASC_CTL0_OFS, {4'h2, c[3:0]});
            reg_rd(ASC_CTL0_OFS, d);
            chk_val(d, {4'h6, c[3:0]});
            chk_val(chan, c[3:0]);
            chk_bit(ext_en, c != 1 && c <= 8);
        end
    endtask
    task automatic t_stall();
        logic [7:0] d;
        int         n;
        n = 0;
        reg_wr(ASC_CTL0_OFS, 8'hA0);
        reg_wr(ASC_CTL0_OFS, 8'h20);
        repeat (100) begin
            @(posedge ref_clk);
            #1 n += clk_en;
        end
        chk_val(n, 0);
        chk_bit(c_pwr, 1'b0);
        reg_rd(ASC_CTL0_OFS, d);
        chk_bit(d[6], 1'b1);
    endtask
    task automatic t_conv(input logic [2:0] dv, input logic bg,
                          input logic fmt);
        logic [7:0]  d, lo, hi;
        logic [11:0] ex;
        int          pulses, last;
        pulses = 0;
        last   = 0;
        ex = bg ? BG_CODE : 12'h3A6;
        reg_wr(ASC_CTL1_OFS, {5'h08, dv});
        reg_wr(ASC_CTL1_OFS, {bg, 4'h8, dv});
        reg_wr(ASC_CTL0_OFS, {3'b000, fmt, 4'h3});
        repeat (SETTLE) @(posedge ref_clk);
        chk_bit(c_pwr, 1'b1);
        chk_bit(ext_en, !bg);
        reg_wr(ASC_CTL0_OFS, {3'b100, fmt, 4'h3});
        reg_rd(ASC_CTL0_OFS, d);
        chk_bit(d[6], 1'b1);
        chk_bit(c_rst, 1'b1);
        reg_wr(ASC_CTL0_OFS, {3'b000, fmt, 4'h3});
        for (int cyc = 0; cyc < 3000; cyc++) begin
            @(posedge ref_clk);
            #1;
            if (irq === 1'b1) break;
            if (clk_en === 1'b1) begin
                if (pulses > 0) chk_val(cyc - last, 1 << dv);
                pulses++;
                last = cyc;
            end
        end
        chk_val(pulses, 16);
        chk_bit(irq, 1'b1);
        @(posedge ref_clk);
        #1 chk_bit(irq, 1'b0);
        reg_rd(ASC_CTL0_OFS, d);
        chk_bit(d[6], 1'b0);
        reg_rd(ASC_RESH_OFS, hi);
        reg_rd(ASC_RESL_OFS, lo);
        chk_val(hi, fmt ? {4'h0, ex[11:8]} : ex[11:4]);
        chk_val(lo, fmt ? ex[7:0] : {ex[3:0], 4'h0});
        reg_wr(ASC_CTL0_OFS, 8'h20);
    endtask
    // ==========================================================
    // Verdict
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        lv_rst = 1'b0;
        lv_det = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        num_errors = 0;
        n_checks = 0;
        cycles = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_ctl1();
        t_chan();
        t_stall();
        for (int k = 0; k < 8; k++) begin
            t_conv(k[2:0], k == 2 || k == 5, k[0]);
        end
        wrap_up();
    end
endmodule

// ==== rtl/asc_ctrl.sv ====
// Sequencing, clock division and reference control for the converter.
// Assumes the analogue core samples on conv_clk_en_q and presents its
// result on adc_data; software drives the plain register port.
//
// Function
// RULE1: Bandgap select routes 1.25V bandgap to converter, cuts external inputs.
// RULE2: Software enables bandgap before selecting it as input.
// RULE3: Bandgap powers down when unused and both low-voltage functions off.
// RULE4: Software waits bandgap settle time before converting.
// RULE5: Bits 5 and 3 of control register one read zero.
// RULE6: Reference select one picks reference pin, zero picks supply.
// RULE7: Reference select high claims the shared pin, drops other functions.
// RULE8: Divider codes 000 to 110 divide system clock by 1 to 64.
// RULE9: Start bit raised then lowered begins a conversion.
// RULE10: While start stays high, converter is reset and busy is high.
// RULE11: Busy flag clears by itself when a conversion ends.
// RULE12: End of conversion raises the interrupt request.
// RULE13: Software may poll busy until zero instead of interrupts.
// RULE14: Software keeps converter clock period within 0.53us to 10us.
// RULE15: Converter powered only while power-off bit is zero.
// RULE16: Software waits power-up delay after clearing power-off.
// RULE17: Software sets power-off whenever converter is idle.
// RULE18: A conversion lasts sixteen converter clock periods.
// RULE19: Channel field picks inputs 0 to 8; code 1 leaves input floating.
// RULE20: Format bit left or right justifies 12-bit result, zero fill.
// RULE21: Prescaler counter gives one converter clock enable per division.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module asc_ctrl
    import asc_pkg::*;
#(
    parameter int DIV_W = 7                      // Prescaler counter width
) (
    input  wire logic        ref_clk,            // System clock, 125 MHz
    input  wire logic        rst_n,              // Async reset, active low
    input  wire logic [1:0]  addr,               // Register address
    input  wire logic [7:0]  wdata,              // Write data
    input  wire logic        wr,                 // Write strobe
    input  wire logic        rd,                 // Read strobe
    output logic      [7:0]  rdata_q,            // Read data, next cycle
    input  wire logic        low_voltage_reset,  // Low-voltage reset enabled
    input  wire logic        low_voltage_detect, // Low-voltage detect enabled
    input  wire logic [11:0] adc_data,           // Result from analogue core
    output logic             conv_clk_en_q,      // Converter clock enable
    output logic             conv_reset_q,       // Converter held in reset
    output logic             conv_power_q,       // Converter powered
    output logic             bandgap_power_q,    // Bandgap circuit on
    output logic             bandgap_route_q,    // Bandgap on converter input
    output logic             ext_chan_en_q,      // External channel connected
    output logic      [3:0]  channel_select_q,   // External channel code
    output logic             vref_pin_sel_q,     // Reference from pin
    output logic             vref_pin_claim_q,   // Shared pin taken for ref
    output logic             irq_request_q       // End of conversion pulse
);
    // Refuse a counter too narrow for the divide by 128 code
    if (DIV_W < 7) begin
        $error("DIV_W must reach a divide by 128");
    end

    // ==========================================================
    // Register storage
    logic                start_q;
    logic                busy_q;
    logic                power_off_q;
    logic                result_format_select_q;
    logic [3:0]          chan_q;
    logic                bandgap_input_select_q;
    logic                bandgap_enable_q;
    logic                reference_source_select_q;
    logic [2:0]          converter_clock_divider_q;
    logic [11:0]         result_q;
    asc_state_type       state_q;
    logic [4:0]          tick_cnt_q;
    logic [DIV_W-1:0]    div_cnt_q;
    logic [DIV_W-1:0]    div_limit;
    logic                div_tick;
    logic                conv_done;
    logic                wr_ctl0;
    logic                wr_ctl1;

    assign wr_ctl0 = wr && (addr == ASC_CTL0_OFS);
    assign wr_ctl1 = wr && (addr == ASC_CTL1_OFS);

    // Control register zero writable fields
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q                <= ASC_CTL0_RST[ASC_START_BIT];
            power_off_q            <= ASC_CTL0_RST[ASC_POFF_BIT];
            result_format_select_q <= ASC_CTL0_RST[ASC_FMT_BIT];
            chan_q                 <= ASC_CTL0_RST[ASC_CHAN_LSB +: ASC_CHAN_W];
        end else if (wr_ctl0) begin
            start_q                <= wdata[ASC_START_BIT];
            power_off_q            <= wdata[ASC_POFF_BIT];
            result_format_select_q <= wdata[ASC_FMT_BIT];
            chan_q                 <= wdata[ASC_CHAN_LSB +: ASC_CHAN_W];
        end
    end

    // Control register one, reserved bits not stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bandgap_input_select_q    <= ASC_CTL1_RST[ASC_BGSEL_BIT];
            bandgap_enable_q          <= ASC_CTL1_RST[ASC_BGEN_BIT];
            reference_source_select_q <= ASC_CTL1_RST[ASC_REFS_BIT];
            converter_clock_divider_q <= ASC_CTL1_RST[ASC_DIV_LSB +: ASC_DIV_W];
        end else if (wr_ctl1) begin
            bandgap_input_select_q    <= wdata[ASC_BGSEL_BIT];
            bandgap_enable_q          <= wdata[ASC_BGEN_BIT];
            reference_source_select_q <= wdata[ASC_REFS_BIT];
            converter_clock_divider_q <= wdata[ASC_DIV_LSB +: ASC_DIV_W];
        end
    end

    // ==========================================================
    // Prescaler: terminal count is two to the code, minus one
    assign div_limit = DIV_W'((8'h01 << converter_clock_divider_q) - 8'h01);
    assign div_tick  = (div_cnt_q >= div_limit);                 // RULE8

    // Held at zero while start is high, so the first tick after release
    // lands one full division later
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= '0;
        end else if (start_q || div_tick) begin
            div_cnt_q <= '0;                                       // RULE21
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;                          // RULE21
        end
    end

    // Converter clock enable, only while powered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_clk_en_q <= 1'b0;
        end else begin
            conv_clk_en_q <= div_tick && !power_off_q && !start_q; // RULE15
        end
    end

    // ==========================================================
    // Conversion sequencer
    // Raising start during a run aborts back to hold, with no request unless conv_done is high in that same cycle
    assign conv_done = (state_q == ASC_RUN) && conv_clk_en_q &&
                       (tick_cnt_q == 5'(ASC_CONV_TICKS - 1));     // RULE18

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ASC_IDLE;
            tick_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ASC_IDLE: begin
                    if (start_q) begin
                        state_q <= ASC_HOLD;
                    end
                end
                ASC_HOLD: begin
                    tick_cnt_q <= '0;
                    if (!start_q) begin
                        state_q <= ASC_RUN;                          // RULE9
                    end
                end
                ASC_RUN: begin
                    if (start_q) begin
                        state_q <= ASC_HOLD;
                    end else if (conv_done) begin
                        state_q <= ASC_IDLE;                         // RULE18
                    end else if (conv_clk_en_q) begin
                        tick_cnt_q <= tick_cnt_q + 5'h01;            // RULE18
                    end
                end
            endcase
        end
    end

    // Busy flag: start sets it, end of conversion clears it
    // A new start outranks a finishing conversion in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= ASC_CTL0_RST[ASC_BUSY_BIT];
        end else if (start_q) begin
            busy_q <= 1'b1;                                          // RULE10
        end else if (conv_done) begin
            busy_q <= 1'b0;                                          // RULE11
        end
    end

    // Converter reset while start held high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_reset_q <= 1'b0;
        end else begin
            conv_reset_q <= start_q;                                 // RULE10
        end
    end

    // Result capture and end of conversion request
    // Result loads at any conv_done, even one in the cycle start rises, so only an earlier abort keeps the old value
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q      <= '0;
            irq_request_q <= 1'b0;
        end else begin
            irq_request_q <= conv_done;                              // RULE12
            if (conv_done) begin
                result_q <= adc_data;
            end
        end
    end

    // ==========================================================
    // Analogue control outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_power_q     <= 1'b0;
            bandgap_power_q  <= 1'b0;
            bandgap_route_q  <= 1'b0;
            ext_chan_en_q    <= 1'b0;
            channel_select_q <= '0;
            vref_pin_sel_q   <= 1'b0;
            vref_pin_claim_q <= 1'b0;
        end else begin
            conv_power_q     <= !power_off_q;                        // RULE15
            bandgap_power_q  <= bandgap_enable_q || low_voltage_reset ||
                                low_voltage_detect;                  // RULE3
            bandgap_route_q  <= bandgap_input_select_q;              // RULE1
            ext_chan_en_q    <= !bandgap_input_select_q &&
                                (chan_q <= ASC_CHAN_MAX) &&
                                (chan_q != ASC_CHAN_FLOAT);          // RULE19
            channel_select_q <= chan_q;                              // RULE19
            vref_pin_sel_q   <= reference_source_select_q;           // RULE6
            vref_pin_claim_q <= reference_source_select_q;           // RULE7
        end
    end

    // ==========================================================
    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                ASC_CTL0_OFS: begin
                    rdata_q <= {start_q, busy_q, power_off_q,
                                result_format_select_q, chan_q};
                end
                ASC_CTL1_OFS: begin
                    rdata_q <= {bandgap_input_select_q, bandgap_enable_q,
                                1'b0, reference_source_select_q, 1'b0,
                                converter_clock_divider_q};          // RULE5
                end
                ASC_RESL_OFS: begin
                    rdata_q <= result_format_select_q ? result_q[7:0] :
                               {result_q[3:0], 4'h0};               // RULE20
                end
                ASC_RESH_OFS: begin
                    rdata_q <= result_format_select_q ?
                               {4'h0, result_q[11:8]} :
                               result_q[11:4];                       // RULE20
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ==========================================================
    // Checks
    // Properties sample registered state, port inputs and combinational decodes; reset disables them
    hold_reset_busy_a: assert property (                         // RULE10
        @(posedge ref_clk) disable iff (!rst_n)
        start_q |=> conv_reset_q && busy_q)
        else $error("start high without reset and busy");

    start_fall_run_a: assert property (                          // RULE9
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == ASC_HOLD) && !start_q |=> state_q == ASC_RUN)
        else $error("start release did not begin conversion");

    done_busy_clear_a: assert property (                         // RULE11
        @(posedge ref_clk) disable iff (!rst_n)
        conv_done && !start_q |=> !busy_q && state_q == ASC_IDLE)
        else $error("busy not cleared at end of conversion");

    irq_one_pulse_a: assert property (                           // RULE12
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(irq_request_q) |-> $past(conv_done) ##1 !irq_request_q)
        else $error("interrupt request not one pulse at end");

    conv_length_a: assert property (                             // RULE18
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == ASC_RUN) && !start_q && conv_clk_en_q &&
        tick_cnt_q == 5'h0F |=> irq_request_q && state_q == ASC_IDLE)
        else $error("conversion length not sixteen ticks");

    tick_bound_a: assert property (                              // RULE18
        @(posedge ref_clk) disable iff (!rst_n)
        state_q == ASC_RUN |-> tick_cnt_q <= 5'h0F)
        else $error("tick count ran past sixteen");

    float_chan_a: assert property (                              // RULE19
        @(posedge ref_clk) disable iff (!rst_n)
        chan_q == ASC_CHAN_FLOAT || chan_q > ASC_CHAN_MAX |=> !ext_chan_en_q)
        else $error("floating or absent channel connected");

    stall_busy_a: assert property (                              // RULE15
        @(posedge ref_clk) disable iff (!rst_n)
        busy_q && power_off_q && $past(power_off_q) && !start_q
        |=> busy_q)
        else $error("conversion ended while powered off");

    bandgap_route_a: assert property (                           // RULE1
        @(posedge ref_clk) disable iff (!rst_n)
        bandgap_input_select_q |=> bandgap_route_q && !ext_chan_en_q)
        else $error("bandgap select left external input on");

    bandgap_power_a: assert property (                           // RULE3
        @(posedge ref_clk) disable iff (!rst_n)
        !bandgap_enable_q && !low_voltage_reset && !low_voltage_detect
        |=> !bandgap_power_q)
        else $error("bandgap stayed on while unused");

    reference_pin_a: assert property (                           // RULE7
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 vref_pin_claim_q == $past(reference_source_select_q) &&
        vref_pin_sel_q == vref_pin_claim_q)
        else $error("reference pin selection mismatch");

    power_gate_a: assert property (                              // RULE15
        @(posedge ref_clk) disable iff (!rst_n)
        power_off_q |=> !conv_power_q && !conv_clk_en_q)
        else $error("converter active while powered off");

    reserved_zero_a: assert property (                           // RULE5
        @(posedge ref_clk) disable iff (!rst_n)
        rd && addr == ASC_CTL1_OFS |=> !rdata_q[5] && !rdata_q[3])
        else $error("reserved bits read nonzero");

    divider_rate_a: assert property (                            // RULE8
        @(posedge ref_clk) disable iff (!rst_n)
        (converter_clock_divider_q == 3'h1 && !start_q && !wr_ctl1 &&
         div_tick) ##1 (!start_q && !wr_ctl1) |-> !div_tick ##1 div_tick)
        else $error("divide by two tick spacing wrong");
endmodule

// ==== rtl/asc_pkg.sv ====
// Constants for the converter sequencing and reference control block.
// Assumes an 8-bit register port and an external analogue converter core.
package asc_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [1:0] ASC_CTL0_OFS  = 2'h0; // Start, busy, power
    localparam logic [1:0] ASC_CTL1_OFS  = 2'h1; // Reference and clock
    localparam logic [1:0] ASC_RESL_OFS  = 2'h2; // Result low byte
    localparam logic [1:0] ASC_RESH_OFS  = 2'h3; // Result high byte
    // ==========================================================
    // Field positions, control register zero
    localparam int ASC_START_BIT = 7;
    localparam int ASC_BUSY_BIT  = 6;
    localparam int ASC_POFF_BIT  = 5;
    localparam int ASC_FMT_BIT   = 4;
    localparam int ASC_CHAN_LSB  = 0;
    localparam int ASC_CHAN_W    = 4;
    // ==========================================================
    // Field positions, control register one
    localparam int ASC_BGSEL_BIT = 7;
    localparam int ASC_BGEN_BIT  = 6;
    localparam int ASC_RSV5_BIT  = 5;
    localparam int ASC_REFS_BIT  = 4;
    localparam int ASC_RSV3_BIT  = 3;
    localparam int ASC_DIV_LSB   = 0;
    localparam int ASC_DIV_W     = 3;
    // ==========================================================
    // Reset values
    localparam logic [7:0] ASC_CTL0_RST  = 8'h60; // Busy and power-off set
    localparam logic [7:0] ASC_CTL1_RST  = 8'h00;
    // ==========================================================
    // Channel codes and timing
    localparam logic [3:0] ASC_CHAN_FLOAT = 4'h1; // No input wired
    localparam logic [3:0] ASC_CHAN_MAX   = 4'h8; // Highest input
    localparam int         ASC_CONV_TICKS = 16;   // Clocks per conversion
    localparam int         ASC_RES_W      = 12;
    // Conversion sequencer states
    typedef enum logic [1:0] {
        ASC_IDLE,
        ASC_HOLD,
        ASC_RUN
    } asc_state_type;
endpackage
